// ### design/dev_reg_port.sv
`timescale 1ns/1ns

module dev_reg_port
  import i2c_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the sequencer
  input wire logic wr_req,
  input wire logic rd_req,
  input wire logic [3:0] addr,
  input wire word_t wdata,
  output word_t rd_data,
  output logic rd_valid,
  // Device register interface
  output logic [3:0] dev_addr,
  output word_t dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire word_t dev_rdata
);

  logic [3:0] addr_q;
  logic [3:0] addr_d;
  word_t wdata_q;
  word_t wdata_d;
  logic wr_q;
  logic rd_q;
  logic pend_q;
  word_t rdat_q;
  word_t rdat_d;

  always_comb begin
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdat_d = rdat_q;
    if (wr_req || rd_req) begin
      addr_d = addr;
      wdata_d = wdata;
    end
    if (rd_q) begin
      rdat_d = dev_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= 4'h0;
      wdata_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pend_q <= 1'b0;
      rdat_q <= 16'h0000;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_req;
      rd_q <= rd_req && !wr_req;
      pend_q <= rd_q;
      rdat_q <= rdat_d;
    end
  end

  assign dev_addr = addr_q;
  assign dev_wdata = wdata_q;
  assign dev_wr = wr_q;
  assign dev_rd = rd_q;
  assign rd_data = rdat_q;
  assign rd_valid = pend_q;

endmodule

// ### design/hold_timer.sv
`timescale 1ns/1ns
`include "i2c_host_defines.svh"

module hold_timer
  import i2c_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output logic done
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = 12'(`HOLD_CYC);
    end else if (cnt_q != 12'h000) begin
      cnt_d = cnt_q - 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == 12'h001);

endmodule

// ### design/i2c_host_ctrl.sv
`timescale 1ns/1ns
`include "i2c_host_defines.svh"

// What this block does
// - After setup, channel is left stopped with serial output disabled.
// - Start: data level low, wait hold time, then clock level low.
// - After start, enable serial output, then set the start trigger.
// - Address and direction written to data low byte send one frame.
// - After transfer end, ack error flag 0 means ack, 1 means nack.
// - Only the transfer end interrupt is used, never buffer empty.
// - Bit rate at most a quarter of channel clock, divider at least one.
// - While running, only data, stop trigger, flag clear and output enable are written.
// - Divider set in the address phase is kept for later phases.
// - For receive: stop trigger, transmit off receive on, start again.
// - Each received byte starts by writing FFH, then read after end.
// - Before the last byte, output enable goes low so no ack is driven.
// - After the final nacked byte, stop trigger then stop condition.
// - After all transmitted bytes, a stop condition releases the bus.
// - Stop: disable output, data low, clock high, wait, data high.
// - The seven bit divider is never zero, at least one.
// - Errors clear by writing the read status value to flag clear.

module i2c_host_ctrl
  import i2c_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software register port
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Device register interface
  output logic [3:0] dev_addr,
  output word_t dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire word_t dev_rdata,
  // Device transfer end interrupt
  input wire logic dev_irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  host_state_e state_q, state_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] txd_q, txd_d;
  logic [7:0] rxd_q, rxd_d;
  logic [6:0] div_q, div_d;
  logic [1:0] flags_q, flags_d;
  logic rx_mode_q, rx_mode_d;
  logic last_q, last_d;
  logic oe_q, oe_d;
  logic run_q, run_d;
  logic done_q, done_d;
  logic nack_q, nack_d;
  logic ovf_q, ovf_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] irq_sync_q;
  logic irq_edge;
  logic wr_req, rd_req, tmr_start, tmr_done, rd_valid;
  logic [3:0] req_addr;
  word_t req_wdata, rd_data;
  logic [2:0] cmd;
  logic busy;

  assign cmd = sw_wdata[2:0];
  assign busy = (state_q != S_IDLE);
  assign irq_edge = irq_sync_q[1] && !irq_sync_q[2];

  function automatic word_t lvl(input logic c, input logic s);
    word_t v;
    v = 16'h0000;
    v[`LVL_CLK_BIT] = c;
    v[`LVL_SDA_BIT] = s;
    return v;
  endfunction

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    byte_d = byte_q;
    rx_mode_d = rx_mode_q;
    last_d = last_q;
    oe_d = oe_q;
    run_d = run_q;
    flags_d = flags_q;
    rxd_d = rxd_q;
    nack_d = nack_q;
    ovf_d = ovf_q;
    done_d = done_q;
    wr_req = 1'b0;
    rd_req = 1'b0;
    req_addr = 4'h0;
    req_wdata = 16'h0000;
    tmr_start = 1'b0;
    if (sw_wr && sw_addr == `H_STAT && sw_wdata[0]) begin
      done_d = 1'b0;
    end
    case (state_q)
      S_IDLE: begin
        if (sw_wr && sw_addr == `H_CTRL) begin
          last_d = sw_wdata[`CTRL_LAST_BIT];
          case (cmd)
            `CMD_START: begin
              byte_d = addr_q;
              rx_mode_d = 1'b0;
              state_d = S_STOP_INIT;
            end
            `CMD_TX: begin
              byte_d = txd_q;
              state_d = S_LOAD;
            end
            `CMD_RX: begin
              byte_d = `RX_DUMMY;
              if (!rx_mode_q) begin
                state_d = S_STOP_RX;
              end else if (sw_wdata[`CTRL_LAST_BIT]) begin
                state_d = S_OE_LAST;
              end else begin
                state_d = S_LOAD;
              end
            end
            `CMD_STOP: begin
              state_d = S_STOP_CH;
            end
            default: begin
              state_d = S_IDLE;
            end
          endcase
        end
      end
      S_STOP_INIT: begin
        wr_req = 1'b1;
        req_addr = `DEV_STOP;
        req_wdata = 16'(1) << `CH_BIT;
        run_d = 1'b0;
        state_d = S_OE_INIT;
      end
      S_OE_INIT: begin
        wr_req = 1'b1;
        req_addr = `DEV_OE;
        oe_d = 1'b0;
        state_d = S_MODE;
      end
      S_MODE: begin
        wr_req = 1'b1;
        req_addr = `DEV_MODE;
        req_wdata = `MODE_VAL;
        state_d = S_OPS_TX;
      end
      S_OPS_TX: begin
        wr_req = 1'b1;
        req_addr = `DEV_OPS;
        req_wdata = 16'(1) << `OPS_TX_BIT;
        state_d = S_DIV;
      end
      S_DIV: begin
        wr_req = 1'b1;
        req_addr = `DEV_DATA;
        req_wdata = {div_q, 9'h000};
        state_d = S_SDA_LOW;
      end
      S_SDA_LOW: begin
        wr_req = 1'b1;
        req_addr = `DEV_LEVEL;
        req_wdata = lvl(1'b1, 1'b0);
        tmr_start = 1'b1;
        state_d = S_HOLD;
      end
      S_HOLD: begin
        if (tmr_done) begin
          state_d = S_SCL_LOW;
        end
      end
      S_SCL_LOW: begin
        wr_req = 1'b1;
        req_addr = `DEV_LEVEL;
        req_wdata = lvl(1'b0, 1'b0);
        state_d = S_OE_ON;
      end
      S_OE_ON: begin
        wr_req = 1'b1;
        req_addr = `DEV_OE;
        req_wdata = 16'(1) << `CH_BIT;
        oe_d = 1'b1;
        state_d = S_RUN;
      end
      S_RUN, S_RESTART: begin
        wr_req = 1'b1;
        req_addr = `DEV_START;
        req_wdata = 16'(1) << `CH_BIT;
        run_d = 1'b1;
        state_d = (state_q == S_RUN) ? S_LOAD :
                  (last_q ? S_OE_LAST : S_LOAD);
      end
      S_LOAD: begin
        wr_req = 1'b1;
        req_addr = `DEV_DATA;
        req_wdata = {div_q, 1'b0, byte_q};
        state_d = S_WAIT_IRQ;
      end
      S_WAIT_IRQ: begin
        if (irq_edge) begin
          state_d = S_RD_STAT;
        end
      end
      S_RD_STAT: begin
        rd_req = 1'b1;
        req_addr = `DEV_STAT;
        state_d = S_STAT_WAIT;
      end
      S_STAT_WAIT: begin
        if (rd_valid) begin
          flags_d = {rd_data[`ST_ACK_BIT], rd_data[`ST_OVF_BIT]};
          nack_d = rd_data[`ST_ACK_BIT];
          ovf_d = rd_data[`ST_OVF_BIT];
          if (rd_data[`ST_ACK_BIT] || rd_data[`ST_OVF_BIT]) begin
            state_d = S_CLR;
          end else begin
            state_d = rx_mode_q ? S_RD_DATA : S_IDLE;
            done_d = !rx_mode_q;
          end
        end
      end
      S_CLR: begin
        wr_req = 1'b1;
        req_addr = `DEV_CLR;
        req_wdata[`ST_ACK_BIT] = flags_q[1];
        req_wdata[`ST_OVF_BIT] = flags_q[0];
        state_d = rx_mode_q ? S_RD_DATA : S_IDLE;
        done_d = !rx_mode_q;
      end
      S_RD_DATA: begin
        rd_req = 1'b1;
        req_addr = `DEV_DATA;
        state_d = S_DATA_WAIT;
      end
      S_DATA_WAIT: begin
        if (rd_valid) begin
          rxd_d = rd_data[7:0];
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_STOP_RX: begin
        wr_req = 1'b1;
        req_addr = `DEV_STOP;
        req_wdata = 16'(1) << `CH_BIT;
        run_d = 1'b0;
        state_d = S_OPS_RX;
      end
      S_OPS_RX: begin
        wr_req = 1'b1;
        req_addr = `DEV_OPS;
        req_wdata = 16'(1) << `OPS_RX_BIT;
        rx_mode_d = 1'b1;
        state_d = S_RESTART;
      end
      S_OE_LAST: begin
        wr_req = 1'b1;
        req_addr = `DEV_OE;
        oe_d = 1'b0;
        state_d = S_LOAD;
      end
      S_STOP_CH: begin
        wr_req = 1'b1;
        req_addr = `DEV_STOP;
        req_wdata = 16'(1) << `CH_BIT;
        run_d = 1'b0;
        state_d = S_OE_END;
      end
      S_OE_END: begin
        wr_req = 1'b1;
        req_addr = `DEV_OE;
        oe_d = 1'b0;
        state_d = S_SDA_LOW2;
      end
      S_SDA_LOW2: begin
        wr_req = 1'b1;
        req_addr = `DEV_LEVEL;
        req_wdata = lvl(1'b0, 1'b0);
        state_d = S_SCL_HIGH;
      end
      S_SCL_HIGH: begin
        wr_req = 1'b1;
        req_addr = `DEV_LEVEL;
        req_wdata = lvl(1'b1, 1'b0);
        tmr_start = 1'b1;
        state_d = S_HOLD2;
      end
      S_HOLD2: begin
        if (tmr_done) begin
          state_d = S_SDA_HIGH;
        end
      end
      S_SDA_HIGH: begin
        wr_req = 1'b1;
        req_addr = `DEV_LEVEL;
        req_wdata = lvl(1'b1, 1'b1);
        rx_mode_d = 1'b0;
        done_d = 1'b1;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  always_comb begin
    addr_d = addr_q;
    txd_d = txd_q;
    div_d = div_q;
    rdata_d = 8'h00;
    if (sw_wr && !busy) begin
      if (sw_addr == `H_ADDR) begin
        addr_d = sw_wdata;
      end
      if (sw_addr == `H_TXD) begin
        txd_d = sw_wdata;
      end
      if (sw_addr == `H_DIV) begin
        div_d = (sw_wdata[6:0] == 7'h00) ? `DIV_MIN : sw_wdata[6:0];
      end
    end
    if (sw_rd) begin
      case (sw_addr)
        `H_ADDR: rdata_d = addr_q;
        `H_TXD: rdata_d = txd_q;
        `H_DIV: rdata_d = {1'b0, div_q};
        `H_STAT: rdata_d = {4'h0, ovf_q, nack_q, busy, done_q};
        `H_RXD: rdata_d = rxd_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      byte_q <= 8'h00;
      addr_q <= 8'h00;
      txd_q <= 8'h00;
      rxd_q <= 8'h00;
      div_q <= `DIV_RESET;
      flags_q <= 2'h0;
      rx_mode_q <= 1'b0;
      last_q <= 1'b0;
      oe_q <= 1'b0;
      run_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      ovf_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_sync_q <= 3'h0;
    end else begin
      state_q <= state_d;
      byte_q <= byte_d;
      addr_q <= addr_d;
      txd_q <= txd_d;
      rxd_q <= rxd_d;
      div_q <= div_d;
      flags_q <= flags_d;
      rx_mode_q <= rx_mode_d;
      last_q <= last_d;
      oe_q <= oe_d;
      run_q <= run_d;
      done_q <= done_d;
      nack_q <= nack_d;
      ovf_q <= ovf_d;
      rdata_q <= rdata_d;
      irq_sync_q <= {irq_sync_q[1:0], dev_irq};
    end
  end

  assign sw_rdata = rdata_q;

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  hold_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .done(tmr_done)
  );

  dev_reg_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .wr_req(wr_req),
    .rd_req(rd_req),
    .addr(req_addr),
    .wdata(req_wdata),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_wr(dev_wr),
    .dev_rd(dev_rd),
    .dev_rdata(dev_rdata)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [11:0] since_sda_q;
  always_ff @(posedge clk) begin
    if (!rst_n || (dev_wr && dev_addr == `DEV_LEVEL
                   && dev_wdata == lvl(1'b1, 1'b0))) begin
      since_sda_q <= 12'h000;
    end else if (since_sda_q != 12'hFFF) begin
      since_sda_q <= since_sda_q + 12'h001;
    end
  end

  sequence reconfig_s;
    ##1 state_q == S_OPS_RX ##1 state_q == S_RESTART;
  endsequence

  a_div_nonzero: assert property (
    dev_wr && dev_addr == `DEV_DATA |-> dev_wdata[15:9] != 7'h00)
    else $error("divider field written as zero");
  a_start_hold: assert property (
    dev_wr && dev_addr == `DEV_LEVEL && dev_wdata == lvl(1'b0, 1'b0)
    && !oe_q && !run_q && !rx_mode_q && state_q == S_OE_ON
    |-> since_sda_q >= 12'(`HOLD_CYC - 1))
    else $error("clock fell before hold time");
  a_oe_before_run: assert property (
    dev_wr && dev_addr == `DEV_START && !rx_mode_q |-> oe_q)
    else $error("start trigger without output enable");
  a_cfg_stopped: assert property (
    state_q == S_SDA_LOW |-> !oe_q && !run_q)
    else $error("start condition while enabled");
  a_rx_dummy: assert property (
    dev_wr && dev_addr == `DEV_DATA && rx_mode_q
    |-> dev_wdata[7:0] == `RX_DUMMY)
    else $error("receive not started with dummy byte");
  a_last_no_ack: assert property (
    state_q == S_LOAD && rx_mode_q && last_q |-> !oe_q)
    else $error("last byte received with output enabled");
  a_clear_same: assert property (
    state_q == S_STAT_WAIT && rd_valid && rd_data[1:0] != 2'h0
    |-> ##2 dev_wr && dev_addr == `DEV_CLR
    && dev_wdata[1:0] == $past(rd_data[1:0], 2))
    else $error("flag clear value differs from status");
  a_rx_switch: assert property (
    state_q == S_STOP_RX |-> reconfig_s)
    else $error("receive switch out of order");
  a_stop_disabled: assert property (
    state_q == S_SDA_HIGH |-> !oe_q && !run_q && $past(tmr_done))
    else $error("data rose without stop preparation");
  a_no_cfg_running: assert property (
    dev_wr && $past(run_q) |-> dev_addr == `DEV_DATA
    || dev_addr == `DEV_STOP || dev_addr == `DEV_CLR
    || (dev_addr == `DEV_OE && state_q == S_LOAD && last_q))
    else $error("locked register written while running");

endmodule

// ### design/i2c_host_defines.svh
`ifndef I2C_HOST_DEFINES_SVH
`define I2C_HOST_DEFINES_SVH

// ----------------------------------------------------------------------
// Device register offsets and fields
// ----------------------------------------------------------------------
`define DEV_MODE 4'h0
`define DEV_OPS 4'h1
`define DEV_DATA 4'h2
`define DEV_LEVEL 4'h3
`define DEV_OE 4'h4
`define DEV_START 4'h5
`define DEV_STOP 4'h6
`define DEV_STAT 4'h7
`define DEV_CLR 4'h8
`define CH_BIT 0
`define LVL_SDA_BIT 0
`define LVL_CLK_BIT 8
`define OPS_TX_BIT 15
`define OPS_RX_BIT 14
`define MODE_VAL 16'h0024
`define ST_OVF_BIT 0
`define ST_ACK_BIT 1
`define DIV_LSB 9
`define DIV_MIN 7'h01
`define RX_DUMMY 8'hFF

// ----------------------------------------------------------------------
// Controller register offsets and fields
// ----------------------------------------------------------------------
`define H_CTRL 4'h0
`define H_ADDR 4'h1
`define H_TXD 4'h2
`define H_DIV 4'h3
`define H_STAT 4'h4
`define H_RXD 4'h5
`define CMD_START 3'h1
`define CMD_TX 3'h2
`define CMD_RX 3'h3
`define CMD_STOP 3'h4
`define CTRL_LAST_BIT 3
`define DIV_RESET 7'h01

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 250
`define HOLD_NS 4700
`define HOLD_CYC ((`HOLD_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### design/i2c_host_pkg.sv
package i2c_host_pkg;

  typedef enum logic [4:0] {
    S_IDLE      = 5'b00000,
    S_STOP_INIT = 5'b00001,
    S_OE_INIT   = 5'b00010,
    S_MODE      = 5'b00011,
    S_OPS_TX    = 5'b00100,
    S_DIV       = 5'b00101,
    S_SDA_LOW   = 5'b00110,
    S_HOLD      = 5'b00111,
    S_SCL_LOW   = 5'b01000,
    S_OE_ON     = 5'b01001,
    S_RUN       = 5'b01010,
    S_LOAD      = 5'b01011,
    S_WAIT_IRQ  = 5'b01100,
    S_RD_STAT   = 5'b01101,
    S_STAT_WAIT = 5'b01110,
    S_CLR       = 5'b01111,
    S_RD_DATA   = 5'b10000,
    S_DATA_WAIT = 5'b10001,
    S_STOP_RX   = 5'b10010,
    S_OPS_RX    = 5'b10011,
    S_RESTART   = 5'b10100,
    S_OE_LAST   = 5'b10101,
    S_STOP_CH   = 5'b10110,
    S_OE_END    = 5'b10111,
    S_SDA_LOW2  = 5'b11000,
    S_SCL_HIGH  = 5'b11001,
    S_HOLD2     = 5'b11010,
    S_SDA_HIGH  = 5'b11011
  } host_state_e;

  typedef logic [15:0] word_t;

endpackage

// ### tb/dev_model.sv
`timescale 1ns/1ns
`include "i2c_host_defines.svh"

module dev_model
  import i2c_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Device register port
  input wire logic [3:0] dev_addr,
  input wire word_t dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output word_t dev_rdata,
  output logic dev_irq,
  // Far-side behaviour chosen by the bench
  input wire logic nack_en,
  input wire logic [7:0] rx_val,
  output logic misuse
);
  word_t stat_q, data_q, ops_q;
  word_t rsel;
  logic run_q;
  int cnt;

  assign rsel = (dev_addr == `DEV_STAT) ? stat_q :
    (dev_addr == `DEV_DATA) ? data_q : 16'h0000;
  assign dev_rdata = dev_rd ? rsel : ~rsel;

  always @(posedge clk) begin
    misuse <= 1'b0;
    dev_irq <= 1'b0;
    if (!rst_n) begin
      stat_q <= 16'h0000;
      data_q <= 16'h0000;
      ops_q <= 16'h0000;
      run_q <= 1'b0;
      cnt <= 0;
    end else begin
      if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 2 || cnt == 1) dev_irq <= 1'b1;
      if (cnt == 2 && ops_q[`OPS_TX_BIT] && nack_en) begin
        stat_q[`ST_ACK_BIT] <= 1'b1;
      end
      if (cnt == 2 && ops_q[`OPS_RX_BIT]) data_q[7:0] <= rx_val;
      if (dev_wr) begin
        if ((run_q && (dev_addr == `DEV_MODE || dev_addr == `DEV_LEVEL ||
            dev_addr == `DEV_START)) || cnt > 0 ||
            (dev_addr == `DEV_DATA && dev_wdata[15:9] == 7'h00)) begin
          misuse <= 1'b1;
        end
        case (dev_addr)
          `DEV_OPS: ops_q <= dev_wdata;
          `DEV_START: run_q <= run_q | dev_wdata[`CH_BIT];
          `DEV_STOP: if (dev_wdata[`CH_BIT]) run_q <= 1'b0;
          `DEV_CLR: stat_q <= stat_q & ~dev_wdata;
          `DEV_DATA: begin
            data_q <= dev_wdata;
            if (run_q) cnt <= 18 * (dev_wdata[15:9] + 1) + 2;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ### tb/i2c_host_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "i2c_host_defines.svh"

module i2c_host_ctrl_tb_top
  import i2c_host_pkg::*;
;
  logic clk, rst_n, sw_wr, sw_rd, nack_en, misuse, dev_wr, dev_rd, dev_irq;
  logic [3:0] sw_addr, dev_addr;
  logic [7:0] sw_wdata, sw_rdata, rx_val, s, b;
  logic [6:0] dv;
  word_t dev_wdata, dev_rdata;
  logic [19:0] obs[$], exq[$];
  int n_fail, check_count, cyc, lvl_cyc, gap;

  i2c_host_ctrl DUT (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_irq(dev_irq));

  dev_model dev (.clk(clk), .rst_n(rst_n), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .dev_irq(dev_irq), .nack_en(nack_en),
    .rx_val(rx_val), .misuse(misuse));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp_wr(logic [19:0] got, logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
    if (dev_wr === 1'b1) begin
      obs.push_back({dev_addr, dev_wdata});
      if (dev_addr === `DEV_LEVEL) begin
        gap <= cyc - lvl_cyc;
        lvl_cyc <= cyc;
      end
    end
    if (rst_n && misuse !== 1'b0) cmp_wr({19'h0, misuse}, 20'h00000);
  end

  task automatic sw_w(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_r(logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  task automatic ex(logic [3:0] a, word_t v);
    exq.push_back({a, v});
  endtask

  task automatic run_cmd(logic [2:0] c, logic last, logic intr,
      logic [7:0] m, logic [7:0] e);
    sw_w(`H_STAT, 8'h01);
    sw_w(`H_CTRL, {4'h0, last, c});
    if (intr) sw_w(`H_CTRL, {5'h00, `CMD_STOP});
    for (int i = 0; i < 3000; i++) begin
      sw_r(`H_STAT, s);
      if (s[1] === 1'b0) break;
    end
    cmp_rd(s & m, e);
    repeat (4) @(posedge clk);
    cmp_wr(20'(obs.size()), 20'(exq.size()));
    while (exq.size() > 0 && obs.size() > 0) begin
      cmp_wr(obs.pop_front(), exq.pop_front());
    end
    obs.delete();
    exq.delete();
  endtask

  task automatic ex_start(logic [7:0] ab);
    ex(`DEV_STOP, 16'h0001);
    ex(`DEV_OE, 16'h0000);
    ex(`DEV_MODE, `MODE_VAL);
    ex(`DEV_OPS, 16'h8000);
    ex(`DEV_DATA, {dv, 9'h000});
    ex(`DEV_LEVEL, 16'h0100);
    ex(`DEV_LEVEL, 16'h0000);
    ex(`DEV_OE, 16'h0001);
    ex(`DEV_START, 16'h0001);
    ex(`DEV_DATA, {dv, 1'b0, ab});
  endtask

  task automatic ex_stop();
    ex(`DEV_STOP, 16'h0001);
    ex(`DEV_OE, 16'h0000);
    ex(`DEV_LEVEL, 16'h0000);
    ex(`DEV_LEVEL, 16'h0100);
    ex(`DEV_LEVEL, 16'h0101);
  endtask

  initial begin
    rst_n = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    nack_en = 1'b0;
    rx_val = 8'h00;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    lvl_cyc = 0;
    gap = 0;
    void'($urandom(32'h5010));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sw_r(4'hF, s);
    cmp_rd(s, 8'h00);
    dv = 7'h01;
    b = {7'($urandom), 1'b0};
    sw_w(`H_DIV, 8'h00);
    sw_w(`H_ADDR, b);
    ex_start(b);
    run_cmd(`CMD_START, 1'b0, 1'b0, 8'hFF, 8'h01);
    cmp_rd({7'h00, gap >= `HOLD_CYC}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      nack_en <= k[0];
      b = 8'($urandom);
      sw_w(`H_TXD, b);
      ex(`DEV_DATA, {dv, 1'b0, b});
      if (k == 1) ex(`DEV_CLR, 16'h0002);
      run_cmd(`CMD_TX, 1'b0, k[0], 8'hFF, {5'h00, k[0], 2'h1});
    end
    nack_en <= 1'b0;
    ex_stop();
    run_cmd(`CMD_STOP, 1'b0, 1'b0, 8'h03, 8'h01);
    cmp_rd({7'h00, gap >= `HOLD_CYC}, 8'h01);
    dv = 7'(2 + $urandom % 4);
    b = {7'($urandom), 1'b1};
    sw_w(`H_DIV, {1'b0, dv});
    sw_w(`H_ADDR, b);
    ex_start(b);
    run_cmd(`CMD_START, 1'b0, 1'b0, 8'h03, 8'h01);
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom);
      rx_val <= b;
      if (k == 0) begin
        ex(`DEV_STOP, 16'h0001);
        ex(`DEV_OPS, 16'h4000);
        ex(`DEV_START, 16'h0001);
      end
      if (k == 2) ex(`DEV_OE, 16'h0000);
      ex(`DEV_DATA, {dv, 1'b0, `RX_DUMMY});
      run_cmd(`CMD_RX, k == 2, 1'b0, 8'h0B, 8'h01);
      sw_r(`H_RXD, s);
      cmp_rd(s, b);
    end
    ex_stop();
    run_cmd(`CMD_STOP, 1'b0, 1'b0, 8'h03, 8'h01);
    give_verdict();
  end
endmodule
